// *** scr_config_regs.sv ***
// serializer configuration and control register bank
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Overview of operation
// - own 7-bit bus address held in address register bits 7:1, host writable
// - address bit 0 set selects register address, clear selects strap pin
// - reset register bit 7 powers down when back-channel link is absent
// - reset register bit 1 resets all logic and registers, then self-clears
// - reset register bit 0 resets logic but keeps registers, then self-clears
// - config0 bit 7 enables back-channel CRC check; config0 resets to d2
// - config0 bit 4 rejects sync/enable pulses shorter than two pixel clocks
// - config0 bit 1 allows automatic fallback to internal oscillator without pixel clock
// - config0 bit 0 picks pixel strobe edge: one rising, zero falling
// - config1 bit 5 clears CRC counters; stays set until software writes zero
// - config1 bit 3 picks legacy mode from register bit, else from strap pin
//----------------------------------------------------------------------
module scr_config_regs
    import scr_pkg::*;
#(
    parameter int SYNC_STAGES = 3
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire scr_pkg::scr_req_t req,
    output logic [7:0] rdata,
    output logic rvalid,
    input wire logic [6:0] address_strap_pin,
    input wire logic mode_strap_pin,
    input wire logic linkDetected,
    input wire logic pixelClockPresent,
    input wire logic data_enable_input,
    input wire logic horizontal_sync_input,
    input wire logic vertical_sync_input,
    output logic data_enable_filt,
    output logic horizontal_sync_filt,
    output logic vertical_sync_filt,
    output scr_pkg::scr_ctrl_t ctrl
);
    import scr_pkg::*;

    //------------------------------------------------------------------
    // register storage
    //------------------------------------------------------------------
    logic [7:0] ownId_q, ownId_d;
    logic [7:0] rstReg_q, rstReg_d;
    logic [7:0] cfg0_q, cfg0_d;
    logic [7:0] cfg1_q, cfg1_d;
    logic [6:0] strapAddr_q;
    logic strapMode_q;

    // the full reset clears the registers too; it is an extra synchronous reset term
    wire regReset = !rst_b || rstReg_q[B_FULL_RST];
    // core reset covers everything except the register file
    wire coreReset = regReset || rstReg_q[B_CORE_RST];

    wire hitOwnId = req.wrEn && (req.addr == ADDR_OWN_ID);
    wire hitReset = req.wrEn && (req.addr == ADDR_RESET);
    wire hitCfg0 = req.wrEn && (req.addr == ADDR_CFG0);
    wire hitCfg1 = req.wrEn && (req.addr == ADDR_CFG1);

    assign ownId_d = hitOwnId ? req.wdata : ownId_q;
    // reset strobes self-clear: a write pulses them for exactly one cycle
    // a full reset also clears the auto power-down bit held here
    assign rstReg_d = hitReset ? (req.wdata & MASK_RESET)
                    : rstReg_q[B_FULL_RST] ? RST_RESET
                    : {rstReg_q[B_AUTO_PD], 7'h00};
    assign cfg0_d = hitCfg0 ? (req.wdata & MASK_CFG0) : cfg0_q;
    // crc clear holds while set; software writes zero to release it
    assign cfg1_d = hitCfg1 ? (req.wdata & MASK_CFG1) : cfg1_q;

    always_ff @(posedge clk) begin
        if (regReset) begin
            ownId_q <= RST_OWN_ID;
            cfg0_q <= RST_CFG0;
            cfg1_q <= RST_CFG1;
        end else begin
            ownId_q <= ownId_d;
            cfg0_q <= cfg0_d;
            cfg1_q <= cfg1_d;
        end
    end

    // the reset register clears only on pin reset so the full-reset strobe can drop again
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rstReg_q <= RST_RESET;
        end else begin
            rstReg_q <= rstReg_d;
        end
    end

    // straps are static levels; sampled on every clock, during reset as well
    always_ff @(posedge clk) begin
        strapAddr_q <= address_strap_pin;
        strapMode_q <= mode_strap_pin;
    end

    //------------------------------------------------------------------
    // pin input synchronisers (three stages, second and third must agree)
    //------------------------------------------------------------------
    logic [4:0] sync1_q, sync2_q, sync3_q, syncStable_q;
    wire [4:0] pinsIn = {linkDetected, pixelClockPresent, data_enable_input,
                         horizontal_sync_input, vertical_sync_input};
    wire [4:0] agree = ~(sync2_q ^ sync3_q);
    always_ff @(posedge clk) begin
        sync1_q <= pinsIn;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
        if (!rst_b) begin
            syncStable_q <= 5'h00;
        end else begin
            syncStable_q <= (agree & sync3_q) | (~agree & syncStable_q);
        end
    end

    //------------------------------------------------------------------
    // two-cycle glitch filter on sync and enable inputs
    //------------------------------------------------------------------
    logic [2:0] filtOut_q;
    logic [1:0] filtCnt_q [3];
    wire [2:0] filtIn = syncStable_q[2:0];
    // a new level must persist two full cycles before it is passed on
    function automatic logic [1:0] filt_count(input logic differs, input logic [1:0] cnt);
        filt_count = differs ? ((cnt == FILT_MIN) ? cnt : cnt + 2'h1) : 2'h0;
    endfunction

    always_ff @(posedge clk) begin
        for (int i = 0; i < 3; i++) begin
            if (coreReset) begin
                filtCnt_q[i] <= 2'h0;
                filtOut_q[i] <= 1'b0;
            end else begin
                filtCnt_q[i] <= filt_count(filtIn[i] != filtOut_q[i], filtCnt_q[i]);
                if (!cfg0_q[B_FILTER] || (filtCnt_q[i] == FILT_MIN - 2'h1)) begin
                    filtOut_q[i] <= filtIn[i];
                end
            end
        end
    end
    assign {data_enable_filt, horizontal_sync_filt, vertical_sync_filt} = filtOut_q;

    //------------------------------------------------------------------
    // decoded control outputs
    //------------------------------------------------------------------
    scr_ctrl_t ctrl_d, ctrl_q;
    always_comb begin
        ctrl_d = '0;
        // register address overrides the strap only when selected
        ctrl_d.busAddr = ownId_q[B_ID_SEL] ? ownId_q[7:1] : strapAddr_q;
        ctrl_d.powerDown = rstReg_q[B_AUTO_PD] && !syncStable_q[4];
        ctrl_d.coreReset = coreReset;
        ctrl_d.crcCheckEn = cfg0_q[B_CRC_EN];
        ctrl_d.crcCountClr = cfg1_q[B_CRC_CLR];
        ctrl_d.remoteAutoAck = cfg0_q[B_AUTO_ACK];
        ctrl_d.passThrough = cfg0_q[B_PASS];
        ctrl_d.useOscillator = cfg0_q[B_OSC_AUTO] && !syncStable_q[3];
        ctrl_d.pixelEdgeSelect = cfg0_q[B_EDGE];
        ctrl_d.failsafeLow = cfg1_q[B_FAILSAFE];
        ctrl_d.legacyCompatMode = cfg1_q[B_COMPAT_SRC] ? cfg1_q[B_COMPAT_REG] : strapMode_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end
    assign ctrl = ctrl_q;

    //------------------------------------------------------------------
    // read port; unmapped and reserved locations read zero
    //------------------------------------------------------------------
    logic [7:0] rdata_d, rdata_q;
    logic rvalid_q;
    always_comb begin
        case (req.addr)
            ADDR_OWN_ID: rdata_d = ownId_q;
            ADDR_RESET: rdata_d = rstReg_q;
            ADDR_CFG0: rdata_d = cfg0_q;
            ADDR_CFG1: rdata_d = cfg1_q;
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= req.rdEn ? rdata_d : rdata_q;
            rvalid_q <= req.rdEn;
        end
    end
    assign rdata = rdata_q;
    assign rvalid = rvalid_q;
endmodule

// *** scr_pkg.sv ***
// package for the serializer configuration register bank
package scr_pkg;
    localparam logic [7:0] ADDR_OWN_ID = 8'h00;
    localparam logic [7:0] ADDR_RESET = 8'h01;
    localparam logic [7:0] ADDR_CFG0 = 8'h03;
    localparam logic [7:0] ADDR_CFG1 = 8'h04;
    localparam logic [7:0] RST_OWN_ID = 8'h00;
    localparam logic [7:0] RST_RESET = 8'h00;
    localparam logic [7:0] RST_CFG0 = 8'hd2;
    localparam logic [7:0] RST_CFG1 = 8'h80;
    localparam logic [7:0] MASK_RESET = 8'h83;
    localparam logic [7:0] MASK_CFG0 = 8'hbb;
    // bit 2 holds the register-chosen legacy mode, so it must stay writable
    localparam logic [7:0] MASK_CFG1 = 8'hac;
    localparam int B_ID_SEL = 0;
    localparam int B_AUTO_PD = 7;
    localparam int B_FULL_RST = 1;
    localparam int B_CORE_RST = 0;
    localparam int B_CRC_EN = 7;
    localparam int B_AUTO_ACK = 5;
    localparam int B_FILTER = 4;
    localparam int B_PASS = 3;
    localparam int B_OSC_AUTO = 1;
    localparam int B_EDGE = 0;
    localparam int B_FAILSAFE = 7;
    localparam int B_CRC_CLR = 5;
    localparam int B_COMPAT_SRC = 3;
    localparam int B_COMPAT_REG = 2;
    localparam logic [1:0] FILT_MIN = 2'h2;

    // register access from the control-bus slave (byte-wide)
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scr_req_t;

    typedef struct packed {
        logic [6:0] busAddr;
        logic powerDown;
        logic coreReset;
        logic crcCheckEn;
        logic crcCountClr;
        logic remoteAutoAck;
        logic passThrough;
        logic useOscillator;
        logic pixelEdgeSelect;
        logic failsafeLow;
        logic legacyCompatMode;
    } scr_ctrl_t;
endpackage

// *** scr_checker.sv ***
// assertion checker for the serializer register bank
`timescale 1ns/1ps
module scr_checker
    import scr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire scr_pkg::scr_req_t req,
    input wire logic rvalid,
    input wire logic linkDetected,
    input wire logic pixelClockPresent,
    input wire scr_pkg::scr_ctrl_t ctrl
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire wrId = req.wrEn && req.addr == ADDR_OWN_ID;
    wire wrRst = req.wrEn && req.addr == ADDR_RESET;
    wire wrCfg0 = req.wrEn && req.addr == ADDR_CFG0;
    wire wrCfg1 = req.wrEn && req.addr == ADDR_CFG1;
    property p_rd; req.rdEn |=> rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_id; wrId && req.wdata[B_ID_SEL] |-> ##2 ctrl.busAddr == $past(req.wdata[7:1], 2); endproperty
    a_id: assert property (p_id) else $error("bus address not taken");
    property p_pd; linkDetected [*8] |-> !ctrl.powerDown; endproperty
    a_pd: assert property (p_pd) else $error("power down with link");
    property p_full; wrRst && req.wdata[B_FULL_RST] |-> ##[2:3] ctrl.crcCheckEn && !ctrl.remoteAutoAck; endproperty
    a_full: assert property (p_full) else $error("full reset lost");
    property p_core; ctrl.coreReset |=> !ctrl.coreReset; endproperty
    a_core: assert property (p_core) else $error("core reset stuck");
    property p_cfg0; wrCfg0 |-> ##2 ctrl.crcCheckEn == $past(req.wdata[B_CRC_EN], 2)
        && ctrl.remoteAutoAck == $past(req.wdata[B_AUTO_ACK], 2) && ctrl.pixelEdgeSelect == $past(req.wdata[B_EDGE], 2);
    endproperty
    a_cfg0: assert property (p_cfg0) else $error("config0 field wrong");
    property p_osc; pixelClockPresent [*8] |-> !ctrl.useOscillator; endproperty
    a_osc: assert property (p_osc) else $error("oscillator with clock");
    property p_clr; wrCfg1 |-> ##2 ctrl.crcCountClr == $past(req.wdata[B_CRC_CLR], 2); endproperty
    a_clr: assert property (p_clr) else $error("counter clear wrong");
    property p_legacy; wrCfg1 && req.wdata[B_COMPAT_SRC] |-> ##2 ctrl.legacyCompatMode == $past(req.wdata[B_COMPAT_REG], 2);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy mode source wrong");
endmodule
bind scr_config_regs scr_checker u_scr_checker (.clk(clk), .rst_b(rst_b), .req(req), .rvalid(rvalid),
    .linkDetected(linkDetected), .pixelClockPresent(pixelClockPresent), .ctrl(ctrl));

// *** scr_host.sv ***
// control-bus host model issuing register reads and writes
`timescale 1ns/1ps
module scr_host
    import scr_pkg::*;
(
    input wire logic clk,
    input wire logic rvalid,
    input wire logic [7:0] rdata,
    output scr_pkg::scr_req_t req
);
    initial req = '0;
    // an idle bus shows inverted address and data so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) req <= '{1'b1, 1'b0, a, d};
        @(negedge clk) req <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk) req <= '{1'b0, 1'b0, ~a, 8'hff};
        d = rvalid ? rdata : 8'hxx;
    endtask
endmodule

// *** test_serializer_config_regs.sv ***
// self-checking testbench for the serializer register bank
`timescale 1ns/1ps
module test_serializer_config_regs;
    import scr_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [6:0] strap = 7'h2a;
    logic modePin = 1'b1, link = 1'b1, pclk = 1'b1, de = 1'b0, hs = 1'b0, vs = 1'b0;
    logic [7:0] rdata, v;
    logic rvalid, deF;
    scr_req_t req;
    scr_ctrl_t ctrl;
    int err_total = 0;
    int n_checks = 0;
    // address, write data, expected read
    logic [23:0] rows [7] = '{24'h03ffbb, 24'h034400, 24'h04ffac, 24'h045704, 24'h00abab, 24'h018080, 24'h02ff00};
    always #2 clk = ~clk;
    scr_config_regs u_scr_config_regs (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata), .rvalid(rvalid),
        .address_strap_pin(strap), .mode_strap_pin(modePin), .linkDetected(link), .pixelClockPresent(pclk),
        .data_enable_input(de), .horizontal_sync_input(hs), .vertical_sync_input(vs),
        .data_enable_filt(deF), .horizontal_sync_filt(), .vertical_sync_filt(), .ctrl(ctrl));
    scr_host u_scr_host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        final_report;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        foreach (rows[i]) begin
            u_scr_host.wr(rows[i][23:16], rows[i][15:8]);
            u_scr_host.rd(rows[i][23:16], v);
            chk(v, rows[i][7:0]);
        end
        chk({1'b0, ctrl.busAddr}, 8'h55);
        u_scr_host.wr(ADDR_OWN_ID, 8'h34);
        @(negedge clk);
        chk({1'b0, ctrl.busAddr}, {1'b0, strap});
        link = 1'b0;
        repeat (6) @(negedge clk);
        chk({7'h00, ctrl.powerDown}, 8'h01);
        link = 1'b1;
        chk({7'h00, ctrl.legacyCompatMode}, {7'h00, modePin});
        u_scr_host.wr(ADDR_CFG1, 8'h2c);
        repeat (4) @(negedge clk);
        chk({7'h00, ctrl.legacyCompatMode}, 8'h01);
        chk({7'h00, ctrl.crcCountClr}, 8'h01);
        chk({7'h00, ctrl.failsafeLow}, 8'h00);
        u_scr_host.wr(ADDR_CFG0, 8'h13);
        pclk = 1'b0;
        de = 1'b1;
        @(negedge clk);
        de = 1'b0;
        repeat (8) @(negedge clk) chk({7'h00, deF}, 8'h00);
        chk({7'h00, ctrl.useOscillator}, 8'h01);
        chk({7'h00, ctrl.passThrough}, 8'h00);
        de = 1'b1;
        repeat (8) @(negedge clk);
        chk({7'h00, deF}, 8'h01);
        u_scr_host.wr(ADDR_RESET, 8'h01);
        u_scr_host.rd(ADDR_CFG0, v);
        chk(v, 8'h13);
        u_scr_host.wr(ADDR_RESET, 8'h82);
        u_scr_host.rd(ADDR_CFG0, v);
        chk(v, RST_CFG0);
        u_scr_host.rd(ADDR_CFG1, v);
        chk(v, RST_CFG1);
        u_scr_host.rd(ADDR_RESET, v);
        chk(v, RST_RESET);
        chk({7'h00, ctrl.failsafeLow}, 8'h01);
        final_report;
    end
endmodule
